/* core/adcrc_pkg.sv */
// adcrc_pkg: constants shared by the converter readout and reset control logic
// assumes a single 25 MHz core clock and synchronous host-side pin inputs
package adcrc_pkg;
   localparam int          CLK_PERIOD_NS = 40;
   localparam int          RESUME_NS     = 20;   // restart delay after reset release
   localparam int          ABORT_NS      = 50;   // latest abort after reset entry
   localparam int          CONV_NS       = 400;  // conversion time
   // longest times round down, never below one cycle
   localparam int          RESUME_CYC    = (RESUME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                           (RESUME_NS / CLK_PERIOD_NS);
   localparam int          ABORT_CYC     = (ABORT_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                           (ABORT_NS / CLK_PERIOD_NS);
   localparam int          CONV_CYC      = CONV_NS / CLK_PERIOD_NS;
   localparam int          DATA_W        = 16;
   localparam int          HALF_W        = 8;
   localparam int          FIFO_DEPTH    = 8;
   localparam int          POR_CONVS     = 3;    // conversions before all state is clean
   localparam logic [7:0]  ALL_ONES_BYTE = 8'hFF;
   localparam logic [15:0] ZERO_WORD     = 16'h0000;
   localparam logic [3:0]  CNT_ZERO      = 4'h0;
   localparam logic [3:0]  CNT_ONE       = 4'h1;
   localparam logic [3:0]  CONV_LAST     = 4'(CONV_CYC - 1);
   localparam logic [3:0]  RESUME_LAST   = 4'(RESUME_CYC);
   localparam logic [1:0]  POR_LAST      = 2'(POR_CONVS);

   // control states, one-hot
   typedef enum logic [3:0] {
      ST_RESET  = 4'b0001,
      ST_RESUME = 4'b0010,
      ST_SAMPLE = 4'b0100,
      ST_CONV   = 4'b1000
   } adcrc_state_t;
endpackage : adcrc_pkg

/* core/adcrc_fifo.sv */
// adcrc_fifo: small synchronous result FIFO with valid/ready on both sides
// assumes one clock; flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none
module adcrc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,     // core clock
   input  wire logic             rstn,    // async reset, active low
   input  wire logic             flush,   // drop all entries
   input  wire logic [WIDTH-1:0] inData,  // write data
   input  wire logic             inValid, // write request
   output logic                  inReady, // space available
   output logic      [WIDTH-1:0] outData, // head entry
   output logic                  outValid,// head valid
   input  wire logic             outReady // reader takes head
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } adcrc_fifo_t;
   adcrc_fifo_t            st_r, st_nxt;
   logic [WIDTH-1:0]       mem [DEPTH];
   logic                   doWr, doRd;

   // full/empty from extra pointer bit
   assign outValid = st_r.wp != st_r.rp;
   assign inReady  = (st_r.wp[AW-1:0] != st_r.rp[AW-1:0]) || (st_r.wp[AW] == st_r.rp[AW]);
   assign outData  = mem[st_r.rp[AW-1:0]];
   assign doWr     = inValid && inReady && !flush;
   assign doRd     = outValid && outReady && !flush;

   always_comb begin
      st_nxt = st_r;
      if (flush) begin
         st_nxt.wp = '0;
         st_nxt.rp = '0;
      end else begin
         if (doWr) st_nxt.wp = st_r.wp + 1'b1;
         if (doRd) st_nxt.rp = st_r.rp + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) st_r <= '0;
      else       st_r <= st_nxt;
   end

   // storage has no reset; only pointers define contents
   always_ff @(posedge clk) begin
      if (doWr) mem[st_r.wp[AW-1:0]] <= inData;
   end
endmodule : adcrc_fifo // adcrc_fifo
`default_nettype wire

/* core/adcrc_ctrl.sv */
// adcrc_ctrl: conversion sequencing, abort-reset and parallel readout of a 16-bit converter
// assumes host pins are synchronous to core_clk; the analog result arrives on convResult
`timescale 1ns/1ps
`default_nettype none
module adcrc_ctrl (
   input  wire logic        core_clk,          // 25 MHz core clock
   input  wire logic        rstn,              // reset pin and power-on reset, active low
   input  wire logic        selectN,           // chip select, active low
   input  wire logic        readN,             // read strobe, active low
   input  wire logic        conversion_start_n,// conversion start, active low
   input  wire logic        byteSel,           // half-word selector
   input  wire logic [15:0] convResult,        // result from the analog core
   output logic      [7:0]  upper_output_lines,// data lines 15..8
   output logic      [7:0]  lower_output_lines,// data lines 7..0
   output logic             dataOeN,           // output enable, low while driving
   output logic             busy,              // conversion in progress
   output logic             sampling,          // track mode active
   output logic             porDone            // three conversions since the last pin or power-on reset
);
   typedef struct packed {
      adcrc_pkg::adcrc_state_t state;
      logic [3:0]              cnt;
      logic                    first;      // next sample follows a reset
      logic                    busyFell;   // busy has ended, sampling pending
      logic                    selPrev;
      logic                    startPrev;
      logic [15:0]             word;       // latched word on output side
      logic [7:0]              upper_r;
      logic [7:0]              lower_r;
      logic                    oeN_r;
      logic                    busy_r;
      logic                    samp_r;
      logic [1:0]              porCnt;
      logic                    por_r;
   } adcrc_st_t;

   adcrc_st_t    st_r, st_nxt;
   logic         selFall, startFall, abortReq, popNow;
   logic [15:0]  fifoData;
   logic         fifoValid, fifoInReady, fifoPush;

   assign selFall   = st_r.selPrev && !selectN;
   assign startFall = st_r.startPrev && !conversion_start_n;
   // either abort condition only counts while converting
   assign abortReq  = (st_r.state == adcrc_pkg::ST_CONV) &&
                      ((startFall && !selectN) || selFall);
   assign fifoPush  = (st_r.state == adcrc_pkg::ST_CONV) &&
                      (st_r.cnt == adcrc_pkg::CONV_LAST) && !abortReq;
   // head leaves the queue on the very edge that latches it, so a read
   // that starts next cycle cannot swallow a queued word
   assign popNow    = fifoValid && (selectN || readN) &&
                      (st_r.state != adcrc_pkg::ST_RESET);

   // results queue between the converter and the output latch; a stalled
   // queue holds the converter in its last cycle rather than dropping a word
   adcrc_fifo #(
      .WIDTH (adcrc_pkg::DATA_W),
      .DEPTH (adcrc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk      (core_clk),
      .rstn     (rstn),
      .flush    (abortReq),
      .inData   (convResult),
      .inValid  (fifoPush),
      .inReady  (fifoInReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (popNow)
   );

   // next-state logic
   always_comb begin
      st_nxt           = st_r;
      st_nxt.selPrev   = selectN;
      st_nxt.startPrev = conversion_start_n;
      case (st_r.state)
         adcrc_pkg::ST_RESET: begin
            // internal reset pulse: clear latches, then resume by itself
            st_nxt.word     = adcrc_pkg::ZERO_WORD;
            st_nxt.busy_r   = 1'b0;
            st_nxt.samp_r   = 1'b0;
            st_nxt.first    = 1'b1;
            st_nxt.busyFell = 1'b0;
            st_nxt.cnt      = adcrc_pkg::CNT_ZERO;
            st_nxt.state    = adcrc_pkg::ST_RESUME;
         end
         adcrc_pkg::ST_RESUME: begin
            // first sample a fixed delay after release, no select edge needed
            st_nxt.cnt = st_r.cnt + adcrc_pkg::CNT_ONE;
            if (st_r.cnt + adcrc_pkg::CNT_ONE >= adcrc_pkg::RESUME_LAST) begin
               st_nxt.state  = adcrc_pkg::ST_SAMPLE;
               st_nxt.samp_r = 1'b1;
               st_nxt.first  = 1'b0;
            end
         end
         adcrc_pkg::ST_SAMPLE: begin
            // track starts at the later of busy fall and select fall
            if (!st_r.samp_r && st_r.busyFell && (selFall || !selectN)) begin
               st_nxt.samp_r   = 1'b1;
               st_nxt.busyFell = 1'b0;
            end
            // start edge with select low moves to hold
            if (startFall && !selectN) begin
               st_nxt.state  = adcrc_pkg::ST_CONV;
               st_nxt.busy_r = 1'b1;
               st_nxt.samp_r = 1'b0;
               st_nxt.cnt    = adcrc_pkg::CNT_ZERO;
            end
         end
         adcrc_pkg::ST_CONV: begin
            if (abortReq) begin
               st_nxt.state  = adcrc_pkg::ST_RESET;
               st_nxt.busy_r = 1'b0;
            end else if (st_r.cnt != adcrc_pkg::CONV_LAST) begin
               st_nxt.cnt = st_r.cnt + adcrc_pkg::CNT_ONE;
            end else if (fifoInReady) begin
               // conversion done, busy falls
               st_nxt.state    = adcrc_pkg::ST_SAMPLE;
               st_nxt.busy_r   = 1'b0;
               st_nxt.busyFell = 1'b1;
               if (st_r.porCnt != adcrc_pkg::POR_LAST)
                  st_nxt.porCnt = st_r.porCnt + 2'b01;
            end
         end
         default: st_nxt.state = adcrc_pkg::ST_RESET;
      endcase
      st_nxt.por_r = (st_nxt.porCnt == adcrc_pkg::POR_LAST);

      // latch the oldest queued word whenever the bus is idle
      if (popNow) begin
         st_nxt.word = fifoData;
      end

      // output lines and enable
      st_nxt.oeN_r = selectN || readN;
      if (byteSel) begin
         st_nxt.upper_r = st_nxt.word[7:0];
         st_nxt.lower_r = adcrc_pkg::ALL_ONES_BYTE;
      end else begin
         st_nxt.upper_r = st_nxt.word[15:8];
         st_nxt.lower_r = st_nxt.word[7:0];
      end
   end

   // async reset covers the pin and power-on reset alike
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_r           <= '0;
         st_r.state     <= adcrc_pkg::ST_RESET;
         st_r.selPrev   <= 1'b1;
         st_r.startPrev <= 1'b1;
         st_r.oeN_r     <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign upper_output_lines = st_r.upper_r;
   assign lower_output_lines = st_r.lower_r;
   assign dataOeN            = st_r.oeN_r;
   assign busy               = st_r.busy_r;
   assign sampling           = st_r.samp_r;
   assign porDone            = st_r.por_r;

   // abort must leave conversion within the abort bound
   a_abort_busy_drop: assert property (@(posedge core_clk) disable iff (!rstn)
      abortReq |=> !busy && st_r.state == adcrc_pkg::ST_RESET)
      else $error("abort did not drop busy");

   // the internal reset lets go by itself, the host does nothing
   a_abort_self_clear: assert property (@(posedge core_clk) disable iff (!rstn)
      abortReq |=> ##1 st_r.state == adcrc_pkg::ST_RESUME)
      else $error("internal reset did not clear itself");

   // the latch is zero once the reset state has passed
   a_reset_zero_word: assert property (@(posedge core_clk) disable iff (!rstn)
      st_r.state == adcrc_pkg::ST_RESET |=> st_r.word == adcrc_pkg::ZERO_WORD)
      else $error("reset left data latch nonzero");

   // keyed on the resume state, so the release edge of the pin cannot fire it early
   a_first_sample: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.state == adcrc_pkg::ST_RESUME &&
       st_r.cnt + adcrc_pkg::CNT_ONE >= adcrc_pkg::RESUME_LAST) |=> sampling)
      else $error("first sample not started after reset");

   // the resume wait is a single cycle
   a_resume_time: assert property (@(posedge core_clk) disable iff (!rstn)
      st_r.state == adcrc_pkg::ST_RESUME |=> st_r.state != adcrc_pkg::ST_RESUME)
      else $error("resume took too long");

   // lines float unless both select and read are low
   a_oe_select_read: assert property (@(posedge core_clk) disable iff (!rstn)
      (selectN || readN) |=> dataOeN)
      else $error("outputs driven without select and read");

   // second byte of an 8-bit read
   a_byte_high_ones: assert property (@(posedge core_clk) disable iff (!rstn)
      byteSel |=> lower_output_lines == adcrc_pkg::ALL_ONES_BYTE
                  && upper_output_lines == st_r.word[7:0])
      else $error("byte high readout wrong");

   // full word, most significant bit on the top line
   a_byte_low_word: assert property (@(posedge core_clk) disable iff (!rstn)
      !byteSel |=> {upper_output_lines, lower_output_lines} == st_r.word)
      else $error("full word readout wrong");

   // a taken start switches track to hold at once
   a_start_busy: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.state == adcrc_pkg::ST_SAMPLE && startFall && !selectN) |=> busy && !sampling)
      else $error("start edge did not enter hold");

   // busy may only fall at the last step or on an abort
   a_busy_length: assert property (@(posedge core_clk) disable iff (!rstn)
      (busy && !abortReq && st_r.cnt != adcrc_pkg::CONV_LAST) |=> busy)
      else $error("busy shorter than conversion");

   // select fall mid-conversion aborts
   a_select_abort: assert property (@(posedge core_clk) disable iff (!rstn)
      (busy && selFall) |=> !busy)
      else $error("select fall did not abort");

   // start with select low mid-conversion aborts like the pin reset
   a_start_abort: assert property (@(posedge core_clk) disable iff (!rstn)
      (busy && startFall && !selectN)
      |=> !busy && st_r.state == adcrc_pkg::ST_RESET)
      else $error("start edge did not abort conversion");

   // an abort drops every queued word so no stale result escapes
   a_abort_flush: assert property (@(posedge core_clk) disable iff (!rstn)
      abortReq
      |=> !fifoValid)
      else $error("abort left words queued");

   // a select fall outside a conversion is an ordinary select
   a_select_idle: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.state == adcrc_pkg::ST_SAMPLE && selFall && conversion_start_n)
      |=> st_r.state == adcrc_pkg::ST_SAMPLE)
      else $error("select fall reset an idle converter");

   // with select high after busy falls, tracking must wait
   a_sample_wait: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.state == adcrc_pkg::ST_SAMPLE && !sampling && selectN)
      |=> !sampling)
      else $error("tracking started before select fall");

   // busy over and select low: tracking starts next edge
   a_sample_go: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.state == adcrc_pkg::ST_SAMPLE && st_r.busyFell && !selectN && !startFall)
      |=> sampling)
      else $error("tracking did not start");

   // tracking ends only by a new conversion
   a_sample_keep: assert property (@(posedge core_clk) disable iff (!rstn)
      sampling
      |=> sampling || busy)
      else $error("tracking ended without a start");

   // no tracking while the converter holds its sample
   a_hold_no_track: assert property (@(posedge core_clk) disable iff (!rstn)
      busy
      |-> !sampling)
      else $error("tracking during conversion");

   // a start with select high is ignored
   a_start_needs_select: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.state == adcrc_pkg::ST_SAMPLE && !(startFall && !selectN))
      |=> !busy)
      else $error("conversion began without a valid start");

   // busy shows exactly the conversion state
   a_busy_in_conv: assert property (@(posedge core_clk) disable iff (!rstn)
      busy == (st_r.state == adcrc_pkg::ST_CONV))
      else $error("busy out of step with conversion");

   // the conversion counter never passes its last step
   a_conv_count: assert property (@(posedge core_clk) disable iff (!rstn)
      st_r.state == adcrc_pkg::ST_CONV
      |-> st_r.cnt <= adcrc_pkg::CONV_LAST)
      else $error("conversion counter overran");

   // a finished conversion queues its word as busy falls
   a_done_queued: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.state == adcrc_pkg::ST_CONV && st_r.cnt == adcrc_pkg::CONV_LAST
       && fifoInReady && !abortReq)
      |=> !busy && fifoValid)
      else $error("finished word not queued");

   // a word leaving the queue lands in the output latch
   a_pop_latch: assert property (@(posedge core_clk) disable iff (!rstn)
      popNow
      |=> st_r.word == $past(fifoData))
      else $error("popped word not latched");

   // outside the reset state, the word stays put while the host reads it
   a_word_hold_read: assert property (@(posedge core_clk) disable iff (!rstn)
      (!selectN && !readN && st_r.state != adcrc_pkg::ST_RESET)
      |=> $stable(st_r.word))
      else $error("word changed during a read");

   // outputs drive one edge after select and read are both low
   a_oe_drive: assert property (@(posedge core_clk) disable iff (!rstn)
      (!selectN && !readN)
      |=> !dataOeN)
      else $error("outputs not driven during read");

   // an internal reset with byteSel low leaves a zero word on the lines
   a_reset_lines_zero: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.state == adcrc_pkg::ST_RESET && !byteSel)
      |=> {upper_output_lines, lower_output_lines} == adcrc_pkg::ZERO_WORD)
      else $error("lines not zero after reset");

   // the reset pulse is one cycle, then the resume wait
   a_reset_self_end: assert property (@(posedge core_clk) disable iff (!rstn)
      st_r.state == adcrc_pkg::ST_RESET
      |=> st_r.state == adcrc_pkg::ST_RESUME)
      else $error("reset state did not end");

   // nothing converts or tracks while the reset is in force
   a_reset_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_r.state == adcrc_pkg::ST_RESET || st_r.state == adcrc_pkg::ST_RESUME)
      |-> !busy && !sampling)
      else $error("activity during reset");

   // the power-up flag holds until the next pin reset
   a_por_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
      porDone
      |=> porDone)
      else $error("power-up flag dropped");

   // the flag follows the conversion count exactly
   a_por_count: assert property (@(posedge core_clk) disable iff (!rstn)
      porDone == (st_r.porCnt == adcrc_pkg::POR_LAST))
      else $error("power-up flag out of step");

   // a corrupt state falls back to the reset state through the default branch
   a_state_onehot: assert property (@(posedge core_clk) disable iff (!rstn)
      $onehot(st_r.state))
      else $error("control state not one-hot");
endmodule : adcrc_ctrl // adcrc_ctrl
`default_nettype wire

/* tb/adcrc_host.sv */
// adcrc_host: host-side pin driver for the converter control block
// assumes the bench calls its tasks; pins change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module adcrc_host (
   input  wire logic core_clk,           // core clock
   output logic      selectN,            // chip select, active low
   output logic      readN,              // read strobe, active low
   output logic      conversion_start_n, // start, active low
   output logic      byteSel             // half-word selector
);
   // idle bus: deselected, no read, start high
   initial begin
      {selectN, readN, conversion_start_n, byteSel} = 4'hE;
   end
   // one bus state, held until the next call; returns at the falling edge
   task automatic pins(input logic [3:0] v);
      @(posedge core_clk);
      {selectN, readN, conversion_start_n, byteSel} <= v;
      @(negedge core_clk);
   endtask
   // start held low a full cycle with select low, well over 20 ns
   task automatic convert();
      pins(4'h6);
      pins(4'h4);
      pins(4'h6);
   endtask
endmodule // adcrc_host
`default_nettype wire

/* tb/adcrc_ctrl_tb.sv */
// adcrc_ctrl_tb: self-checking bench for the converter control block
// assumes adcrc_host drives the host pins and the bench plays the analog core
`timescale 1ns/1ps
`default_nettype none
module adcrc_ctrl_tb;
   logic        core_clk, rstn, selectN, readN, conversion_start_n, byteSel;
   logic [15:0] convResult;
   logic [7:0]  upper_output_lines, lower_output_lines;
   logic        dataOeN, busy, sampling, porDone, busyInReset;
   int          num_errors = 0;
   int          total_checks = 0;
   int          hi;
   // free-running 25 MHz clock
   always #20 core_clk = ~core_clk;
   adcrc_ctrl uut (.core_clk, .rstn, .selectN, .readN, .conversion_start_n, .byteSel,
      .convResult, .upper_output_lines, .lower_output_lines, .dataOeN, .busy, .sampling,
      .porDone);
   adcrc_host host (.core_clk, .selectN, .readN, .conversion_start_n, .byteSel);
   // checks happen at falling edges, away from the sampling edge
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic [15:0] lanes();
      return {upper_output_lines, lower_output_lines};
   endfunction
   // bus state, then one edge for the registered outputs to follow
   task automatic rd(input logic [3:0] v);
      host.pins(v);
      cyc(1);
   endtask
   task automatic doReset();
      @(posedge core_clk);
      rstn <= 1'b0;
      @(negedge core_clk);
      busyInReset = busy;
      @(posedge core_clk);
      rstn <= 1'b1;
      @(negedge core_clk);
   endtask
   task automatic waitSamp();
      int n;
      n = 0;
      while (sampling !== 1'b1 && n < 4) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic startConv(input logic [15:0] val);
      int n;
      n = 0;
      @(posedge core_clk);
      convResult <= val;
      host.convert();
      while (busy !== 1'b1 && n < 4) begin
         cyc(1);
         n++;
      end
      chk("busy rise", 16'h0001, 16'(busy));
      chk("hold", 16'h0000, 16'(sampling));
   endtask
   // bounded count of busy-high cycles, so a stuck busy cannot hang
   task automatic endConv();
      hi = 0;
      while (busy === 1'b1 && hi < 30) begin
         cyc(1);
         hi++;
      end
   endtask
   task automatic t_boot();
      cyc(1);
      chk("lanes rst", 16'h0000, lanes());
      chk("oe rst", 16'h0001, 16'(dataOeN));
      chk("busy rst", 16'h0000, 16'(busy));
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      cyc(2);
      chk("samp e1", 16'h0000, 16'(sampling));
      cyc(1);
      chk("samp e2", 16'h0001, 16'(sampling));
      chk("por", 16'h0000, 16'(porDone));
      $display("done boot");
   endtask
   task automatic t_read();
      startConv(16'hA53C);
      endConv();
      chk("busy len", 16'(adcrc_pkg::CONV_CYC), 16'(hi));
      cyc(2);
      rd(4'h2);
      chk("oe rd", 16'h0000, 16'(dataOeN));
      chk("word", 16'hA53C, lanes());
      rd(4'h3);
      chk("lo byte", 16'h3CFF, lanes());
      rd(4'h7);
      chk("oe idle", 16'h0001, 16'(dataOeN));
      rd(4'h3);
      chk("lo byte tog", 16'h3CFF, lanes());
      rd(4'hE);
      $display("done read");
   endtask
   // select up across the busy fall: sampling must wait for select low
   task automatic t_nine();
      startConv(16'h1234);
      rd(4'hE);
      endConv();
      cyc(2);
      chk("samp wait", 16'h0000, 16'(sampling));
      rd(4'h6);
      cyc(1);
      chk("samp go", 16'h0001, 16'(sampling));
      rd(4'h2);
      chk("word2", 16'h1234, lanes());
      rd(4'hE);
      $display("done sample");
   endtask
   task automatic t_por();
      chk("por 2", 16'h0000, 16'(porDone));
      startConv(16'hFFFF);
      endConv();
      cyc(2);
      chk("por 3", 16'h0001, 16'(porDone));
      $display("done por");
   endtask
   task automatic t_abStart();
      startConv(16'h0F0F);
      rd(4'h4);
      chk("abort busy", 16'h0000, 16'(busy));
      rd(4'h6);
      waitSamp();
      chk("abort samp", 16'h0001, 16'(sampling));
      rd(4'h2);
      chk("abort lanes", 16'h0000, lanes());
      rd(4'hE);
      $display("done abort start");
   endtask
   task automatic t_abSel();
      startConv(16'h5A5A);
      rd(4'hE);
      rd(4'h6);
      chk("sel busy", 16'h0000, 16'(busy));
      waitSamp();
      chk("sel samp", 16'h0001, 16'(sampling));
      $display("done abort select");
   endtask
   task automatic t_rstMid();
      startConv(16'hC3C3);
      doReset();
      chk("rst busy", 16'h0000, 16'(busyInReset));
      cyc(1);
      chk("rst samp", 16'h0000, 16'(sampling));
      cyc(1);
      chk("rst samp2", 16'h0001, 16'(sampling));
      chk("rst por", 16'h0000, 16'(porDone));
      $display("done reset");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // main sequence; reset held two cycles at start
   initial begin
      core_clk = 1'b0;
      rstn = 1'b0;
      convResult = 16'h0000;
      t_boot();
      t_read();
      t_nine();
      t_por();
      t_abStart();
      t_abSel();
      t_rstMid();
      test_done();
   end
   // watchdog: the tests take about a hundred cycles
   initial begin
      #(5000 * 40);
      num_errors++;
      test_done();
   end
endmodule // adcrc_ctrl_tb
`default_nettype wire
